// File: design/aih_defs.svh
// Constants of the bus-side host interface: offsets, fields, timing.
// Assumes a 200 MHz core clock; included by the package users.
`ifndef AIH_DEFS_SVH
`define AIH_DEFS_SVH
// Register select that reads the acquisition result buffer.
`define AIH_FIFO_SEL 5'h00
// Interrupt source bit positions.
`define AIH_SRC_NE 0
`define AIH_SRC_HF 1
`define AIH_SRC_DONE 2
`define AIH_SRC_TC 3
`define AIH_SRC_DAC 4
`define AIH_SRC_N 5
`define AIH_IRQ_N 11
`define AIH_DRQ_N 3
// Not-ready stretch at the start of an access, in ns, and cycle count.
`define AIH_CLK_MHZ 200
`define AIH_WAIT_NS 100
`define AIH_WAIT_CYC ((`AIH_WAIT_NS * `AIH_CLK_MHZ + 999) / 1000)
`endif

// File: design/aih_pkg.sv
// Types shared by the bus-side host interface.
// Assumes nothing of its surroundings.
package aih_pkg;
  // Bus cycle states, one-hot.
  typedef enum logic [2:0] {
    BUS_IDLE = 3'h1,
    BUS_RD = 3'h2,
    BUS_WR = 3'h4
  } aih_bus_t;
endpackage : aih_pkg

// File: design/aih_fifo.sv
// Result buffer of flip-flops with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module aih_fifo #(
  parameter int W = 16,
  parameter int D = 256
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Filling side.
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  // Draining side.
  input wire logic i_out_ready,
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  // Fill level.
  output logic [$clog2(D):0] o_count
);
  localparam int AW = $clog2(D);
  // Refuse depths that the pointer arithmetic cannot serve.
  if (D < 2 || (1 << AW) != D) begin : g_bad
    $error("aih_fifo depth must be a power of two");
  end
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } aih_fifo_st_t;
  aih_fifo_st_t st_r, st_nxt;
  logic push, pop;
  assign o_in_ready = (st_r.cnt != D[AW:0]);
  assign o_out_valid = (st_r.cnt != '0);
  assign o_out_data = st_r.mem[st_r.rp];
  assign o_count = st_r.cnt;
  assign push = i_in_valid && o_in_ready;
  assign pop = i_out_ready && o_out_valid;
  // Pointer and level update; a full buffer refuses the word.
  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.mem[st_r.wp] = i_in_data;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop)
      st_nxt.rp = st_r.rp + 1'b1;
    st_nxt.cnt = st_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end
  // Storage is not reset; only the pointers and the level are.
  always_ff @(posedge i_ref_clk)
  begin
    st_r <= st_nxt;
    if (!i_rst_b)
    begin
      st_r.wp <= '0;
      st_r.rp <= '0;
      st_r.cnt <= '0;
    end
  end
endmodule : aih_fifo
`default_nettype wire

// File: design/aih_host_if.sv
// Bus-side host interface: address decode, data buffers, width and
// ready signalling, shared interrupt line and DMA requests.
// Assumes bus pins arrive asynchronous and are synchronised here, and
// that configuration inputs come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "aih_defs.svh"
module aih_host_if #(
  parameter int DEPTH = 256,
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Bus address and timing pins.
  input wire logic [9:0] i_sa,
  input wire logic i_bale,
  input wire logic i_aen,
  input wire logic i_ior_b,
  input wire logic i_iow_b,
  input wire logic i_sbhe_b,
  input wire logic i_tc,
  input wire logic [`AIH_DRQ_N-1:0] i_dack_b,
  // Bus data pins.
  input wire logic [15:0] i_sd,
  output logic [15:0] o_sd,
  output logic o_sd_oe,
  // Width, ready and select returns (open drain, pulled low).
  output logic o_cs16,
  output logic o_cs16_oe,
  output logic o_chrdy,
  output logic o_chrdy_oe,
  // Interrupt and DMA request lines.
  output logic [`AIH_IRQ_N-1:0] o_irq,
  output logic [`AIH_IRQ_N-1:0] o_irq_oe,
  output logic [`AIH_DRQ_N-1:0] o_drq,
  // Configuration from board logic.
  input wire logic [4:0] i_base,
  input wire logic [3:0] i_irq_sel,
  input wire logic [`AIH_SRC_N-1:0] i_int_en,
  input wire logic [`AIH_SRC_N-1:0] i_int_clr,
  input wire logic i_dma_en,
  input wire logic [1:0] i_dma_ch,
  input wire logic i_dma_dual,
  input wire logic i_ovf_clr,
  // Board-side register access.
  output logic o_brd_en,
  output logic [4:0] o_reg_sel,
  output logic o_rd_stb,
  output logic o_wr_stb,
  output logic [15:0] o_wr_data,
  output logic o_wide,
  input wire logic [15:0] i_reg_rdata,
  // Acquisition results and events.
  input wire logic i_res_valid,
  input wire logic [W-1:0] i_res_data,
  output logic o_res_ready,
  input wire logic i_daq_done,
  input wire logic i_dac_upd,
  output logic o_ovf,
  output logic [`AIH_SRC_N-1:0] o_int_flag
);
  // The read path is a bus word; other widths cannot be served.
  if (W != 16 || DEPTH < 4) begin : g_bad
    $error("aih_host_if needs 16-bit data and depth of 4 or more");
  end
  localparam int CW = $clog2(DEPTH) + 1;
  localparam int WC = `AIH_WAIT_CYC;
  // Synchronised pin group: address, bale, aen, ior, iow, sbhe, tc, dack.
  localparam int PW = 10 + 6 + `AIH_DRQ_N;
  typedef struct packed {
    logic [PW-1:0] s1;
    logic [PW-1:0] s2;
    logic [15:0] sd1;
    logic [15:0] sd2;
    logic [9:0] adr;
    logic sbhe;
    aih_pkg::aih_bus_t bus;
    logic [7:0] wcnt;
    logic [15:0] sd;
    logic sd_oe;
    logic cs16_oe;
    logic rdy_oe;
    logic brd;
    logic rd;
    logic wr;
    logic [`AIH_IRQ_N-1:0] irq_oe;
    logic [`AIH_SRC_N-1:0] flag;
    logic ne_d;
    logic hf_d;
    logic dac_d;
    logic tc_d;
    logic dac_rq;
    logic [`AIH_DRQ_N-1:0] drq;
    logic ovf;
    logic res_rdy;
  } aih_st_t;
  aih_st_t st_r, st_nxt;
  // Buffer side signals.
  logic f_valid, f_ready, f_pop;
  logic [W-1:0] f_data;
  logic [CW-1:0] f_cnt;
  // Decoded views of the second synchroniser stage.
  logic [9:0] p_sa;
  logic p_bale, p_aen, p_ior, p_iow, p_sbhe, p_tc;
  logic [`AIH_DRQ_N-1:0] p_dack;
  logic dec_hit, any_dack, res_ne, res_hf, dac_fall, irq_on;
  logic [`AIH_SRC_N-1:0] ev;
  assign {p_sa, p_bale, p_aen, p_ior, p_iow, p_sbhe, p_tc, p_dack} = st_r.s2;
  assign any_dack = ~&p_dack;
  // Board is hit when SA9..SA5 match and no DMA owns the address.
  assign dec_hit = !p_aen && (st_r.adr[9:5] == i_base);
  assign res_ne = f_valid;
  assign res_hf = (f_cnt >= CW'(DEPTH / 2));
  assign dac_fall = st_r.dac_d && !i_dac_upd;
  // Maps a channel code to its request line; code 3 wraps to line 0.
  function automatic logic [`AIH_DRQ_N-1:0] ch_bit(input logic [1:0] c);
    ch_bit = (c == 2'h0) ? 3'h1 : (c == 2'h1) ? 3'h2 :
             (c == 2'h2) ? 3'h4 : 3'h1;
  endfunction : ch_bit
  // Pops once, in the cycle that sees the read strobe released, so a
  // long strobe never drains more than the one word it returned.
  assign f_pop = (st_r.bus == aih_pkg::BUS_RD) && !p_ior &&
    ((st_r.brd && st_r.adr[4:0] == `AIH_FIFO_SEL) || any_dack);
  aih_fifo #(.W(W), .D(DEPTH)) aih_fifo_i (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_in_valid(i_res_valid),
    .i_in_data(i_res_data),
    .o_in_ready(f_ready),
    .i_out_ready(f_pop),
    .o_out_valid(f_valid),
    .o_out_data(f_data),
    .o_count(f_cnt)
  );
  // Next-state logic for the whole interface.
  always_comb
  begin
    st_nxt = st_r;
    // Pins pass two stages before any logic reads them.
    st_nxt.s1 = {i_sa, i_bale, i_aen, ~i_ior_b, ~i_iow_b, ~i_sbhe_b,
                 i_tc, i_dack_b};
    st_nxt.s2 = st_r.s1;
    st_nxt.sd1 = i_sd;
    st_nxt.sd2 = st_r.sd1;
    // Address is open while BALE is high and held afterwards.
    if (p_bale)
    begin
      st_nxt.adr = p_sa;
      st_nxt.sbhe = p_sbhe;
    end
    st_nxt.brd = dec_hit;
    st_nxt.rd = 1'b0;
    st_nxt.wr = 1'b0;
    if (st_r.wcnt != 8'h00)
      st_nxt.wcnt = st_r.wcnt - 8'h01;
    unique case (st_r.bus)
      aih_pkg::BUS_IDLE:
      begin
        // A strobe opens a cycle; its kind sets the buffer direction.
        if (p_ior && (dec_hit || any_dack))
        begin
          st_nxt.bus = aih_pkg::BUS_RD;
          st_nxt.wcnt = 8'(WC);
          st_nxt.rd = dec_hit;
        end
        else if (p_iow && (dec_hit || any_dack))
        begin
          st_nxt.bus = aih_pkg::BUS_WR;
          st_nxt.wcnt = 8'(WC);
        end
      end
      aih_pkg::BUS_RD:
      begin
        // The cycle ends when the read strobe is released.
        if (!p_ior)
          st_nxt.bus = aih_pkg::BUS_IDLE;
      end
      aih_pkg::BUS_WR:
      begin
        // Write data is taken as the write strobe is released.
        if (!p_iow)
        begin
          st_nxt.bus = aih_pkg::BUS_IDLE;
          st_nxt.wr = 1'b1;
        end
      end
    endcase
    // Drive data only during an enabled or acknowledged read.
    st_nxt.sd_oe = (st_nxt.bus == aih_pkg::BUS_RD);
    st_nxt.sd = (any_dack || st_r.adr[4:0] == `AIH_FIFO_SEL) ?
                f_data : i_reg_rdata;
    // Width, selected and not-ready returns.
    st_nxt.cs16_oe = (dec_hit && !st_r.adr[0] && st_r.sbhe) ||
                     any_dack;
    st_nxt.rdy_oe = (st_nxt.bus != aih_pkg::BUS_IDLE) &&
                    (st_nxt.wcnt != 8'h00);
    // Interrupt events; a set in the clearing cycle wins.
    st_nxt.ne_d = res_ne;
    st_nxt.hf_d = res_hf;
    st_nxt.tc_d = p_tc;
    st_nxt.dac_d = i_dac_upd;
    ev = '0;
    ev[`AIH_SRC_NE] = res_ne && !st_r.ne_d;
    ev[`AIH_SRC_HF] = res_hf && !st_r.hf_d;
    ev[`AIH_SRC_DONE] = i_daq_done || (!f_ready && i_res_valid);
    ev[`AIH_SRC_TC] = p_tc && !st_r.tc_d;
    ev[`AIH_SRC_DAC] = dac_fall;
    st_nxt.flag = (st_r.flag & ~i_int_clr) | ev;
    // Overflow: the word beyond capacity is dropped.
    st_nxt.ovf = (st_r.ovf && !i_ovf_clr) ||
                 (i_res_valid && !f_ready);
    // Result input is refused from the edge that flags the overflow.
    st_nxt.res_rdy = !st_nxt.ovf;
    // One enabled flag drives the selected line; otherwise float.
    irq_on = |(st_nxt.flag & i_int_en);
    st_nxt.irq_oe = '0;
    if (irq_on && i_irq_sel < 4'(`AIH_IRQ_N))
      st_nxt.irq_oe[i_irq_sel] = 1'b1;
    // DMA requests; dual mode puts updates on the next channel.
    if (dac_fall)
      st_nxt.dac_rq = 1'b1;
    else if (any_dack && st_r.bus == aih_pkg::BUS_WR)
      st_nxt.dac_rq = 1'b0;
    st_nxt.drq = '0;
    if (i_dma_en)
    begin
      if (res_ne || (st_r.dac_rq && !i_dma_dual))
        st_nxt.drq = ch_bit(i_dma_ch);
      if (st_r.dac_rq && i_dma_dual)
        st_nxt.drq = st_nxt.drq |
                     ch_bit(i_dma_ch + 2'h1);
      st_nxt.drq = st_nxt.drq & p_dack;
    end
  end
  // One register stage for all state; reset is synchronous.
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      st_r <= '0;
      st_r.s1 <= {10'h000, 6'h00, 3'h7};
      st_r.s2 <= {10'h000, 6'h00, 3'h7};
      st_r.bus <= aih_pkg::BUS_IDLE;
    end
    else
      st_r <= st_nxt;
  end
  // Outputs straight from the state register; the two open-drain levels are constant low.
  assign o_sd = st_r.sd;
  assign o_sd_oe = st_r.sd_oe;
  assign o_cs16 = 1'b0;
  assign o_cs16_oe = st_r.cs16_oe;
  assign o_chrdy = 1'b0;
  assign o_chrdy_oe = st_r.rdy_oe;
  assign o_irq = st_r.irq_oe;
  assign o_irq_oe = st_r.irq_oe;
  assign o_drq = st_r.drq;
  assign o_brd_en = st_r.brd;
  assign o_reg_sel = st_r.adr[4:0];
  assign o_rd_stb = st_r.rd;
  assign o_wr_stb = st_r.wr;
  assign o_wr_data = st_r.sd2;
  assign o_wide = st_r.cs16_oe;
  assign o_res_ready = st_r.res_rdy;
  assign o_ovf = st_r.ovf;
  assign o_int_flag = st_r.flag;
  // Checks on the interface behaviour.
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  chk_addr_hold: assert property (
    !st_r.s2[PW-11] |=> st_r.adr == $past(st_r.adr))
    else $error("address changed while latch closed");
  chk_sd_drive: assert property (
    o_sd_oe |-> $past(p_ior, 1) && (st_r.bus == aih_pkg::BUS_RD))
    else $error("data driven outside a read");
  chk_no_wr_drive: assert property (
    st_r.bus == aih_pkg::BUS_WR |-> !o_sd_oe)
    else $error("data driven during a write");
  chk_irq_float: assert property (
    !(|(st_r.flag & i_int_en)) |=> o_irq_oe == '0 || $past(irq_on))
    else $error("interrupt driven with nothing pending");
  chk_irq_one: assert property (
    $onehot0(o_irq_oe))
    else $error("more than one interrupt line driven");
  chk_flag_sticky: assert property (
    st_r.flag[`AIH_SRC_TC] && !i_int_clr[`AIH_SRC_TC]
    |=> st_r.flag[`AIH_SRC_TC])
    else $error("flag lost without clear");
  chk_set_wins: assert property (
    dac_fall |=> st_r.flag[`AIH_SRC_DAC])
    else $error("update edge not flagged");
  chk_ovf_set: assert property (
    i_res_valid && !f_ready |=> o_ovf [*2])
    else $error("overflow not flagged");
  chk_drq_off: assert property (
    !i_dma_en |=> o_drq == '0)
    else $error("DMA request with DMA off");
  chk_wait_len: assert property (
    $rose(o_chrdy_oe) |-> o_chrdy_oe [*8])
    else $error("not-ready stretch too short");
  cov_rd: cover property (st_r.rd ##[1:20] !o_sd_oe);
  cov_wr: cover property (o_wr_stb);
  cov_irq: cover property ($rose(|o_irq_oe));
  cov_dma: cover property ($rose(|o_drq));
endmodule : aih_host_if
`default_nettype wire

// File: test/aih_isa_host.sv
// Behavioural host processor and DMA controller on the bus pins.
// Assumes the device samples these pins on the same 200 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module aih_isa_host (
  // Clock.
  input wire logic i_ref_clk,
  // Device returns.
  input wire logic [15:0] i_dev_sd,
  input wire logic i_dev_sd_oe,
  input wire logic i_rdy_oe,
  input wire logic i_cs_oe,
  // Bus pins towards the device.
  output var logic [9:0] o_sa,
  output var logic o_bale,
  output var logic o_aen,
  output var logic o_ior_b,
  output var logic o_iow_b,
  output var logic o_sbhe_b,
  output var logic o_tc,
  output var logic [2:0] o_dack_b,
  output logic [15:0] o_sd
);
  logic drv = 1'b0; // High while the host drives write data.
  logic [15:0] wdat = 16'h0000; // Write data held on the lines.
  logic [15:0] last = 16'h0000; // Last level, to toggle when released.
  // A released data bus shows a changing pattern, never stale data.
  assign o_sd = drv ? wdat : (i_dev_sd_oe ? i_dev_sd : ~last);
  always @(posedge i_ref_clk) last <= o_sd;
  // Idle pin levels from time zero.
  initial
  begin
    o_sa = 10'h000; o_bale = 1'b0; o_aen = 1'b0; o_ior_b = 1'b1;
    o_iow_b = 1'b1; o_sbhe_b = 1'b1; o_tc = 1'b0; o_dack_b = 3'h7;
  end
  // One I/O or DMA transfer; strobe held until ready is seen high.
  task automatic io(input logic [9:0] a, input logic ae,
    input logic [2:0] dk, input logic wr, input logic wide,
    input logic [15:0] wd, output logic [15:0] rd, output logic cs,
    output logic hit, output logic so);
    int n;
    @(posedge i_ref_clk);
    o_sa <= a; o_aen <= ae; o_dack_b <= dk; o_bale <= 1'b1;
    o_sbhe_b <= ~wide; drv <= wr; wdat <= wd;
    repeat (3) @(posedge i_ref_clk);
    o_bale <= 1'b0;
    @(posedge i_ref_clk);
    if (wr) o_iow_b <= 1'b0; else o_ior_b <= 1'b0;
    repeat (5) @(posedge i_ref_clk);
    hit = i_rdy_oe;
    cs = i_cs_oe;
    n = 0;
    while (i_rdy_oe === 1'b1 && n < 100)
    begin
      @(posedge i_ref_clk);
      n++;
    end
    rd = i_dev_sd;
    so = i_dev_sd_oe;
    o_ior_b <= 1'b1; o_iow_b <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    drv <= 1'b0; o_dack_b <= 3'h7; o_aen <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
  endtask : io
  // Terminal count pulse at the end of a DMA block.
  task automatic pulse_tc;
    @(posedge i_ref_clk) o_tc <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    o_tc <= 1'b0;
  endtask : pulse_tc
endmodule : aih_isa_host
`default_nettype wire

// File: test/aih_host_if_tb.sv
// Self-checking bench of the bus-side host interface.
// Assumes the host model above and a 32-word result buffer.
`timescale 1ns/100ps
`default_nettype none
module aih_host_if_tb;
  localparam logic [4:0] BASE = 5'h0B; // Board base on SA9..SA5.
  logic clk = 1'b0, rst_b = 1'b0;
  logic [9:0] sa; logic bale, aen, ior_b, iow_b, sbhe_b, tc;
  logic [2:0] dack_b; logic [15:0] sd, o_sd;
  logic o_sd_oe, o_cs16, o_cs16_oe, o_chrdy, o_chrdy_oe;
  logic [10:0] o_irq, o_irq_oe; logic [2:0] o_drq;
  logic [4:0] base = BASE, int_en = 5'h00, int_clr = 5'h00;
  logic [3:0] irq_sel = 4'hF; logic [1:0] dma_ch = 2'h0;
  logic dma_en = 1'b0, dma_dual = 1'b0, ovf_clr = 1'b0;
  logic o_brd_en, o_rd_stb, o_wr_stb, o_wide, o_res_ready, o_ovf;
  logic [4:0] o_reg_sel, o_int_flag; logic [15:0] o_wr_data;
  logic [15:0] reg_rdata = 16'h0000, res_data = 16'h0000;
  logic res_valid = 1'b0, daq_done = 1'b0, dac_upd = 1'b0;
  logic [15:0] rd, wr_d; logic [4:0] wr_s; logic cs, hit, so;
  int failures = 0, n_checks = 0, wr_n = 0, rd_n = 0;
  // 200 MHz clock.
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  aih_host_if #(.DEPTH(32), .W(16)) aih_host_if_i (.i_ref_clk(clk),
    .i_rst_b(rst_b), .i_sa(sa), .i_bale(bale), .i_aen(aen),
    .i_ior_b(ior_b), .i_iow_b(iow_b), .i_sbhe_b(sbhe_b), .i_tc(tc),
    .i_dack_b(dack_b), .i_sd(sd), .o_sd(o_sd), .o_sd_oe(o_sd_oe),
    .o_cs16(o_cs16), .o_cs16_oe(o_cs16_oe), .o_chrdy(o_chrdy),
    .o_chrdy_oe(o_chrdy_oe), .o_irq(o_irq), .o_irq_oe(o_irq_oe),
    .o_drq(o_drq), .i_base(base), .i_irq_sel(irq_sel),
    .i_int_en(int_en), .i_int_clr(int_clr), .i_dma_en(dma_en),
    .i_dma_ch(dma_ch), .i_dma_dual(dma_dual), .i_ovf_clr(ovf_clr),
    .o_brd_en(o_brd_en), .o_reg_sel(o_reg_sel), .o_rd_stb(o_rd_stb),
    .o_wr_stb(o_wr_stb), .o_wr_data(o_wr_data), .o_wide(o_wide),
    .i_reg_rdata(reg_rdata), .i_res_valid(res_valid),
    .i_res_data(res_data), .o_res_ready(o_res_ready),
    .i_daq_done(daq_done), .i_dac_upd(dac_upd), .o_ovf(o_ovf),
    .o_int_flag(o_int_flag));
  aih_isa_host aih_isa_host_i (.i_ref_clk(clk), .i_dev_sd(o_sd),
    .i_dev_sd_oe(o_sd_oe), .i_rdy_oe(o_chrdy_oe), .i_cs_oe(o_cs16_oe),
    .o_sa(sa), .o_bale(bale), .o_aen(aen), .o_ior_b(ior_b),
    .o_iow_b(iow_b), .o_sbhe_b(sbhe_b), .o_tc(tc), .o_dack_b(dack_b),
    .o_sd(sd));
  // Counts board strobes and keeps the last write seen.
  always @(posedge clk)
  begin
    if (o_wr_stb === 1'b1)
    begin
      wr_n++; wr_d = o_wr_data; wr_s = o_reg_sel;
    end
    if (o_rd_stb === 1'b1) rd_n++;
  end
  // Compares one value and reports a mismatch.
  task automatic chk(input string nm, input logic [15:0] seen,
    input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Bus transfer through the host model.
  task automatic io(input logic [9:0] a, input logic ae,
    input logic [2:0] dk, input logic wr, input logic wide,
    input logic [15:0] wd);
    aih_isa_host_i.io(a, ae, dk, wr, wide, wd, rd, cs, hit, so);
  endtask : io
  // Pushes back-to-back results counting up from st.
  task automatic push(input int n, input logic [15:0] st);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk) res_valid <= 1'b1;
      res_data <= st + 16'(i);
    end
    @(posedge clk) res_valid <= 1'b0;
    cyc(4);
  endtask : push
  task automatic clear(input logic [4:0] m);
    @(posedge clk) int_clr <= m;
    @(posedge clk) int_clr <= 5'h00;
    cyc(3);
  endtask : clear
  // Decode, direction, width and strobes of register access.
  task automatic t_regs;
    io({BASE, 5'h04}, 1'b0, 3'h7, 1'b1, 1'b1, 16'h5AC3);
    chk("wr_hit", hit, 1'b1);
    chk("wr_cs16", cs, 1'b1);
    chk("wr_data", wr_d, 16'h5AC3);
    chk("wr_sel", wr_s, 5'h04);
    chk("wr_brd", o_brd_en, 1'b1);
    chk("wr_wide", o_wide, 1'b1);
    @(posedge clk) reg_rdata <= 16'h3C96;
    io({BASE, 5'h02}, 1'b0, 3'h7, 1'b0, 1'b1, 16'h0000);
    chk("rd_data", rd, 16'h3C96);
    chk("rd_oe", so, 1'b1);
    chk("rd_cnt", 16'(rd_n), 16'h0001);
    io({BASE, 5'h07}, 1'b0, 3'h7, 1'b0, 1'b0, 16'h0000);
    chk("rd8_cs16", cs, 1'b0);
    io({~BASE, 5'h02}, 1'b0, 3'h7, 1'b0, 1'b1, 16'h0000);
    chk("miss_oe", so, 1'b0);
    chk("miss_brd", o_brd_en, 1'b0);
    io({BASE, 5'h02}, 1'b1, 3'h7, 1'b0, 1'b1, 16'h0000);
    chk("aen_oe", so, 1'b0);
    io({~BASE, 5'h04}, 1'b0, 3'h7, 1'b1, 1'b1, 16'h1111);
    chk("miss_cnt", 16'(rd_n + wr_n), 16'h0003);
  endtask : t_regs
  // Fill past capacity, then drain in order.
  task automatic t_fifo;
    @(posedge clk) int_en <= 5'h1F;
    push(16, 16'h1000);
    chk("ne_flag", o_int_flag[0], 1'b1);
    chk("hf_flag", o_int_flag[1], 1'b1);
    push(16, 16'h1010);
    chk("ovf_early", o_ovf, 1'b0);
    push(1, 16'hDEAD);
    chk("ovf", o_ovf, 1'b1);
    chk("ready", o_res_ready, 1'b0);
    chk("done_flag", o_int_flag[2], 1'b1);
    for (int i = 0; i < 32; i++)
    begin
      io({BASE, 5'h00}, 1'b0, 3'h7, 1'b0, 1'b1, 16'h0000);
      chk("fifo_word", rd, 16'h1000 + 16'(i));
    end
    @(posedge clk) ovf_clr <= 1'b1;
    @(posedge clk) ovf_clr <= 1'b0;
    clear(5'h1F);
    chk("ovf_clr", o_ovf, 1'b0);
    chk("flags_clr", o_int_flag, 5'h00);
  endtask : t_fifo
  // Line selection, masking and independent clears.
  task automatic t_irq;
    @(posedge clk) int_en <= 5'h08;
    aih_isa_host_i.pulse_tc();
    cyc(6);
    chk("tc_flag", o_int_flag[3], 1'b1);
    for (int s = 0; s < 12; s++)
    begin
      @(posedge clk) irq_sel <= 4'(s);
      cyc(4);
      chk("irq_line", o_irq_oe, (s < 11) ? 16'h0001 << s : 16'h0000);
    end
    @(posedge clk) irq_sel <= 4'h0;
    int_en <= 5'h00;
    cyc(4);
    chk("irq_masked", o_irq_oe, 11'h000);
    @(posedge clk) int_en <= 5'h10;
    dac_upd <= 1'b1;
    cyc(4);
    dac_upd <= 1'b0;
    cyc(4);
    chk("dac_flag", o_int_flag[4], 1'b1);
    clear(5'h08);
    chk("tc_cleared", o_int_flag[4:3], 2'h2);
    chk("irq_on", o_irq_oe, 11'h001);
    chk("irq_level", o_irq, 11'h001);
    @(posedge clk) daq_done <= 1'b1;
    @(posedge clk) daq_done <= 1'b0;
    cyc(4);
    chk("done_ev", o_int_flag[2], 1'b1);
  endtask : t_irq
  // Requests on every channel code, served by DMA reads.
  // The update left pending by t_irq is served first by a DMA write.
  task automatic t_dma;
    int b;
    @(posedge clk) dma_en <= 1'b1;
    cyc(3);
    chk("drq_upd", o_drq, 3'h1);
    io(10'h000, 1'b1, 3'h6, 1'b1, 1'b1, 16'h0ABC);
    chk("drq_upd_done", o_drq, 3'h0);
    for (int c = 0; c < 4; c++)
    begin
      b = (c == 3) ? 0 : c;
      @(posedge clk) dma_ch <= 2'(c);
      push(1, 16'h2000 + 16'(c));
      chk("drq_ch", o_drq, 3'h1 << b);
      io(10'h000, 1'b1, ~(3'h1 << b), 1'b0, 1'b1, 16'h0000);
      chk("dma_word", rd, 16'h2000 + 16'(c));
      chk("drq_idle", o_drq, 3'h0);
    end
    @(posedge clk) dma_ch <= 2'h0;
    dma_dual <= 1'b1;
    dac_upd <= 1'b1;
    cyc(3);
    dac_upd <= 1'b0;
    cyc(4);
    chk("drq_dual", o_drq, 3'h2);
  endtask : t_dma
  // Prints the verdict and ends the run.
  task automatic close_out;
    if (failures == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  // Watchdog well beyond the expected run length.
  initial
  begin
    #(40000 * 5);
    failures++;
    close_out();
  end
  // Main sequence.
  initial
  begin
    cyc(11);
    chk("rst_oe", o_sd_oe, 1'b0);
    chk("rst_irq", o_irq_oe, 11'h000);
    @(posedge clk) rst_b <= 1'b1;
    cyc(4);
    t_regs();
    t_fifo();
    t_irq();
    t_dma();
    close_out();
  end
endmodule : aih_host_if_tb
`default_nettype wire
